/* design/sac_pkg.sv */
// Purpose: Shared constants and types for the converter control block.
// Assumes: 100 MHz system clock, AXI4-Lite register access with 32-bit data.
// Notes:   Every offset, the control reset value and the bit cycle count live here.
package sac_pkg;

    localparam int CLK_MHZ = 100;
    localparam int RES_W   = 16;

    // Each successive-approximation step lasts one bit time from the internal timebase.
    localparam int BIT_NS  = 30;
    localparam int BIT_CYC = (BIT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0] BIT_LAST = 2'(BIT_CYC - 1);

    localparam logic [15:0] SIGN_FLIP  = 16'h8000;
    localparam logic [15:0] MASK_FIRST = 16'h8000;
    // Compressed span: code 0 at 10 % and full scale at 90 % of the input span.
    localparam logic [15:0] GC_OFFS    = 16'h199a;
    localparam logic [15:0] GC_MUL     = 16'hcccd;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_COUNT  = 8'h0c;

    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_START_BIT = 1;
    localparam logic CTRL_EN_RST  = 1'b1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int PIN_W = 5;

    typedef enum logic [1:0]
    {
        ST_ACQ  = 2'b01,
        ST_CONV = 2'b10
    } sac_state_t;

endpackage : sac_pkg

/* design/sac_sync.sv */
// Purpose: Two-flop synchroniser for a group of pins from outside the clock domain.
// Assumes: Bits are independent levels; no bus coherence is needed.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module sac_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            meta_q <= '0;
            q_out  <= '0;
        end
        else if (ce_in)
        begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end

endmodule : sac_sync

/* design/sac_top.sv */
// Purpose: Conversion sequencer and serial readout of a 16-bit SAR converter.
// Assumes: COMP_IN is a latched comparator clocked by CLK_SYS_IN; other pins are asynchronous.
// Notes:   Software sees control, status, result and count over AXI4-Lite.
// Function
// - Chain select low gives normal mode; shared pin enables serial output.
// - Chain select high gives chain mode; shared pin is upstream serial input.
// - Rising convert-start wakes the converter and starts a conversion.
// - Busy rises when a conversion starts and falls when it completes.
// - While output enabled, shift data out at each rising serial clock, MSB first.
// - Serial result is coded as two's complement.
// - At conversion end a 16-bit word is formed and loaded for transfer.
// - SAR search tries one binary-weighted bit per step down to one LSB.
// - Grounded strap compresses codes to 10-90 % of span; otherwise no scaling.
// - Conversion is timed internally; host gives no conversion clock.
// - Converter powers down after each conversion until the next start.
// - Each result is ready within its own conversion, no pipeline delay.
// - Between conversions the capacitor array tracks the input.
// - Chain mode shifts out own result and upstream data with serial clock.
`timescale 1ns/1ps
module sac_top (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RST_IN,
    input  wire logic        CE_IN,
    input  wire logic        CONVERT_START_IN,
    input  wire logic        CHAIN_IN,
    input  wire logic        OE_OR_CHAIN_IN,
    input  wire logic        GAIN_STRAP_IN,
    input  wire logic        SCK_IN,
    input  wire logic        COMP_IN,
    output logic             SDO_OUT,
    output logic             SDO_OE_OUT,
    output logic             BUSY_OUT,
    output logic             PWR_UP_OUT,
    output logic             TRACK_OUT,
    output logic [15:0]      DAC_CODE_OUT,
    input  wire logic [7:0]  AXI_AWADDR_IN,
    input  wire logic        AXI_AWVALID_IN,
    output logic             AXI_AWREADY_OUT,
    input  wire logic [31:0] AXI_WDATA_IN,
    input  wire logic [3:0]  AXI_WSTRB_IN,
    input  wire logic        AXI_WVALID_IN,
    output logic             AXI_WREADY_OUT,
    output logic [1:0]       AXI_BRESP_OUT,
    output logic             AXI_BVALID_OUT,
    input  wire logic        AXI_BREADY_IN,
    input  wire logic [7:0]  AXI_ARADDR_IN,
    input  wire logic        AXI_ARVALID_IN,
    output logic             AXI_ARREADY_OUT,
    output logic [31:0]      AXI_RDATA_OUT,
    output logic [1:0]       AXI_RRESP_OUT,
    output logic             AXI_RVALID_OUT,
    input  wire logic        AXI_RREADY_IN
);

    logic [sac_pkg::PIN_W-1:0] pins_s;
    logic                      conv_pin_s;
    logic                      chain_s;
    logic                      shared_s;
    logic                      strap_s;
    logic                      sck_s;
    logic                      conv_prev_q;
    logic                      sck_prev_q;

    // The shared pin passes inverted, so a cleared synchroniser reads as a disabled output.
    sac_sync #(
        .WIDTH (sac_pkg::PIN_W)
    ) u_sync (
        .clk_in (CLK_SYS_IN),
        .rst_in (RST_IN),
        .ce_in  (CE_IN),
        .d_in   ({CONVERT_START_IN, CHAIN_IN, ~OE_OR_CHAIN_IN, GAIN_STRAP_IN, SCK_IN}),
        .q_out  (pins_s)
    );

    assign conv_pin_s = pins_s[4];
    assign chain_s    = pins_s[3];
    assign shared_s   = ~pins_s[2];
    assign strap_s  = pins_s[1];
    assign sck_s    = pins_s[0];

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            conv_prev_q <= 1'b0;
            sck_prev_q <= 1'b0;
        end
        else if (CE_IN)
        begin
            conv_prev_q <= conv_pin_s;
            sck_prev_q <= sck_s;
        end
    end

    wire conv_rise = conv_pin_s & ~conv_prev_q;
    wire sck_rise = sck_s & ~sck_prev_q;

    // Control register state.
    logic ctrl_en_q;
    logic soft_start_q;

    // Conversion sequencer.
    sac_pkg::sac_state_t state_q;
    logic [1:0]          cnt_q;
    logic [15:0]         mask_q;
    logic [15:0]         res_q;
    logic [15:0]         result_q;
    logic [15:0]         count_q;
    logic [15:0]         dac_q;
    logic [15:0]         shift_q;
    logic                oe_q;

    wire busy       = (state_q == sac_pkg::ST_CONV);
    wire start      = ~busy & ((conv_rise & ctrl_en_q) | soft_start_q);
    wire bit_end    = busy & (cnt_q == sac_pkg::BIT_LAST);
    wire done       = bit_end & mask_q[0];
    wire [15:0] trial      = res_q | mask_q;
    wire [15:0] final_code = COMP_IN ? trial : res_q;

    // The strap grounded scales the reference trial into the compressed span.
    wire        gc_active = ~strap_s;
    wire [31:0] gc_prod   = trial * sac_pkg::GC_MUL;
    wire [15:0] dac_d     = gc_active ? (sac_pkg::GC_OFFS + gc_prod[31:16]) : trial;

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            state_q <= sac_pkg::ST_ACQ;
        end
        else if (CE_IN)
        begin
            if (start)
            begin
                state_q <= sac_pkg::ST_CONV;
            end
            else if (done)
            begin
                state_q <= sac_pkg::ST_ACQ;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            cnt_q  <= 2'h0;
            mask_q <= 16'h0000;
            res_q  <= 16'h0000;
        end
        else if (CE_IN)
        begin
            if (start)
            begin
                cnt_q  <= 2'h0;
                mask_q <= sac_pkg::MASK_FIRST;
                res_q  <= 16'h0000;
            end
            else if (bit_end)
            begin
                cnt_q  <= 2'h0;
                mask_q <= mask_q >> 1;
                res_q  <= final_code;
            end
            else if (busy)
            begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            result_q <= 16'h0000;
            count_q  <= 16'h0000;
            dac_q    <= 16'h0000;
        end
        else if (CE_IN)
        begin
            dac_q <= dac_d;
            if (done)
            begin
                result_q <= final_code;
                count_q  <= count_q + 16'h0001;
            end
        end
    end

    // Serial side: in chain mode the word always moves and upstream bits follow it.
    wire shift_en = chain_s | ~shared_s;
    wire fill_bit = chain_s & shared_s;

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            shift_q <= 16'h0000;
            oe_q    <= 1'b0;
        end
        else if (CE_IN)
        begin
            oe_q <= shift_en;
            if (done)
            begin
                shift_q <= final_code ^ sac_pkg::SIGN_FLIP;
            end
            else if (~busy & sck_rise & shift_en)
            begin
                shift_q <= {shift_q[14:0], fill_bit};
            end
        end
    end

    assign SDO_OUT      = shift_q[15];
    assign SDO_OE_OUT   = oe_q;
    assign BUSY_OUT     = busy;
    assign PWR_UP_OUT   = busy;
    assign TRACK_OUT    = ~busy;
    assign DAC_CODE_OUT = dac_q;

    // AXI4-Lite slave: address and data are held independently until both are present.
    logic        aw_hold_q;
    logic [7:0]  awaddr_q;
    logic        w_hold_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;

    wire aw_take  = AXI_AWVALID_IN & AXI_AWREADY_OUT;
    wire w_take   = AXI_WVALID_IN & AXI_WREADY_OUT;
    wire wr_go    = CE_IN & aw_hold_q & w_hold_q & ~bvalid_q;
    wire wr_ctrl  = wr_go & (awaddr_q == sac_pkg::ADDR_CTRL) & wstrb_q[0];
    wire wr_known = (awaddr_q == sac_pkg::ADDR_CTRL) | (awaddr_q == sac_pkg::ADDR_STATUS)
                  | (awaddr_q == sac_pkg::ADDR_RESULT) | (awaddr_q == sac_pkg::ADDR_COUNT);
    wire ar_take  = AXI_ARVALID_IN & AXI_ARREADY_OUT;

    assign AXI_AWREADY_OUT = CE_IN & ~aw_hold_q & ~bvalid_q;
    assign AXI_WREADY_OUT  = CE_IN & ~w_hold_q & ~bvalid_q;
    assign AXI_BVALID_OUT  = bvalid_q;
    assign AXI_BRESP_OUT   = bresp_q;
    assign AXI_ARREADY_OUT = CE_IN & ~rvalid_q;
    assign AXI_RVALID_OUT  = rvalid_q;
    assign AXI_RRESP_OUT   = rresp_q;
    assign AXI_RDATA_OUT   = rdata_q;

    wire [31:0] rd_status = {28'h0000000, gc_active, chain_s, ctrl_en_q, busy};
    wire        rd_known  = (AXI_ARADDR_IN == sac_pkg::ADDR_CTRL)
                          | (AXI_ARADDR_IN == sac_pkg::ADDR_STATUS)
                          | (AXI_ARADDR_IN == sac_pkg::ADDR_RESULT)
                          | (AXI_ARADDR_IN == sac_pkg::ADDR_COUNT);
    wire [31:0] rd_mux =
        (AXI_ARADDR_IN == sac_pkg::ADDR_CTRL)   ? {31'h00000000, ctrl_en_q} :
        (AXI_ARADDR_IN == sac_pkg::ADDR_STATUS) ? rd_status :
        (AXI_ARADDR_IN == sac_pkg::ADDR_RESULT) ? {16'h0000, result_q ^ sac_pkg::SIGN_FLIP} :
        (AXI_ARADDR_IN == sac_pkg::ADDR_COUNT)  ? {16'h0000, count_q} : 32'h00000000;

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= 8'h00;
            w_hold_q  <= 1'b0;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
        end
        else if (CE_IN)
        begin
            if (aw_take)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= AXI_AWADDR_IN;
            end
            else if (wr_go)
            begin
                aw_hold_q <= 1'b0;
            end
            if (w_take)
            begin
                w_hold_q <= 1'b1;
                wdata_q  <= AXI_WDATA_IN;
                wstrb_q  <= AXI_WSTRB_IN;
            end
            else if (wr_go)
            begin
                w_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= sac_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q  <= sac_pkg::RESP_OKAY;
            rdata_q  <= 32'h00000000;
        end
        else if (CE_IN)
        begin
            if (wr_go)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_known ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
            end
            else if (AXI_BREADY_IN)
            begin
                bvalid_q <= 1'b0;
            end
            if (ar_take)
            begin
                rvalid_q <= 1'b1;
                rresp_q  <= rd_known ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
                rdata_q  <= rd_mux;
            end
            else if (AXI_RREADY_IN)
            begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Start bit is a one-shot; it is dropped once a conversion has begun.
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            ctrl_en_q    <= sac_pkg::CTRL_EN_RST;
            soft_start_q <= 1'b0;
        end
        else if (CE_IN)
        begin
            if (wr_ctrl)
            begin
                ctrl_en_q <= wdata_q[sac_pkg::CTRL_EN_BIT];
            end
            if (wr_ctrl & wdata_q[sac_pkg::CTRL_START_BIT])
            begin
                soft_start_q <= 1'b1;
            end
            else if (start)
            begin
                soft_start_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (RST_IN);

    a_busy_on_start: assert property (
        (CE_IN && !busy && conv_rise && ctrl_en_q) |=> busy)
        else $error("busy did not rise after convert start");

    a_busy_min_len: assert property (
        $rose(busy) |-> busy[*8])
        else $error("conversion ended too early");

    a_busy_ends: assert property (
        $rose(busy) |-> ##[40:200] !busy)
        else $error("conversion did not finish in time");

    a_load_twos: assert property (
        $fell(busy) |-> (shift_q == (result_q ^ 16'h8000)))
        else $error("serial word not two's complement of result");

    a_shift_msb: assert property (
        (CE_IN && !busy && !done && sck_rise && shift_en)
        |=> (shift_q[15] == $past(shift_q[14])))
        else $error("serial word did not advance MSB first");

    a_chain_fill: assert property (
        (CE_IN && !busy && !done && sck_rise && chain_s)
        |=> (shift_q[0] == $past(shared_s)))
        else $error("upstream bit not captured in chain mode");

    a_oe_normal: assert property (
        (CE_IN && !chain_s && shared_s) |=> !SDO_OE_OUT)
        else $error("output driven while disabled");

    a_oe_chain: assert property (
        (CE_IN && chain_s) |=> SDO_OE_OUT)
        else $error("output not driven in chain mode");

    a_sar_step: assert property (
        (CE_IN && bit_end && !mask_q[0]) |=> (mask_q == ($past(mask_q) >> 1)))
        else $error("trial bit did not step down by one");

endmodule : sac_top

/* verif/sac_host_model.sv */
// Purpose: Far-side model: ideal comparator plus a host reading serial frames.
// Assumes: Serial clock idles low and runs only inside a frame.
// Notes:   Upstream chain data is presented half a period ahead of each rise.
`timescale 1ns/1ps
module sac_host_model (
    input  wire logic        sdo_in,
    input  wire logic        sdo_oe_in,
    input  wire logic        chain_in,
    input  wire logic        rd_en_in,
    input  wire logic [15:0] dac_in,
    input  wire logic [15:0] vin_in,
    input  wire logic [15:0] up_word_in,
    output logic             comp_out,
    output logic             sck_out,
    output logic             oe_or_chain_out
);
    logic up_q;

    initial
    begin
        sck_out = 1'b0;
        up_q    = 1'b0;
    end

    assign comp_out        = vin_in > dac_in;
    assign oe_or_chain_out = chain_in ? up_q : ~rd_en_in;

    // A released output is read as the inverse of the last bit, never as a held value.
    task automatic read_frame(input int nbits, output logic [31:0] word);
        logic bit_v;
        begin
            word = 32'h0;
            #3;
            for (int i = 0; i < nbits; i++)
            begin
                up_q = (i < 16) ? up_word_in[4'(15 - i)] : ~up_q;
                #80;
                bit_v   = sdo_oe_in ? sdo_in : ~word[0];
                word    = {word[30:0], bit_v};
                sck_out = 1'b1;
                #80;
                sck_out = 1'b0;
            end
        end
    endtask : read_frame
endmodule : sac_host_model

/* verif/sac_top_bench.sv */
// Purpose: Self-checking bench for the converter sequencer and serial readout.
// Assumes: 100 MHz clock, host model at the serial side, AXI4-Lite master here.
// Notes:   Expected codes come from a bench-side search model.
`timescale 1ns/1ps
module sac_top_bench;
    localparam logic [15:0] UP_WORD = 16'h5a3c;
    logic        clk, rst, ce, conv_pin, chain, strap, rd_en;
    logic [15:0] vin;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awvalid, wvalid, bready, arvalid, rready;
    wire         sck, comp, oe_ci, sdo, sdo_oe, busy, pwr, track;
    wire         awready, wready, bvalid, arready, rvalid;
    wire  [15:0] dac;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          n_mismatch, check_count;

    sac_top dut_u (
        .CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce), .CONVERT_START_IN(conv_pin), .CHAIN_IN(chain),
        .OE_OR_CHAIN_IN(oe_ci), .GAIN_STRAP_IN(strap), .SCK_IN(sck), .COMP_IN(comp),
        .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .BUSY_OUT(busy), .PWR_UP_OUT(pwr),
        .TRACK_OUT(track), .DAC_CODE_OUT(dac), .AXI_AWADDR_IN(awaddr),
        .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata),
        .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
        .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
        .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
        .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
        .AXI_RREADY_IN(rready)
    );

    sac_host_model host_u (
        .sdo_in(sdo), .sdo_oe_in(sdo_oe), .chain_in(chain), .rd_en_in(rd_en), .dac_in(dac),
        .vin_in(vin), .up_word_in(UP_WORD), .comp_out(comp), .sck_out(sck),
        .oe_or_chain_out(oe_ci)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done;
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask : test_done

    task automatic chk(input logic ok, input string msg);
        begin
            check_count++;
            if (ok !== 1'b1)
            begin
                n_mismatch++;
                $display("MISMATCH %0t %s", $time, msg);
            end
        end
    endtask : chk

    // Handshakes are judged at the falling edge before the rising edge that takes them.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ag, wg, bg;
        begin
            @(posedge clk);
            awaddr  <= a;
            wdata   <= d;
            {awvalid, wvalid, bready} <= 3'b111;
            do
            begin
                @(negedge clk);
                ag = awvalid && awready;
                wg = wvalid && wready;
                bg = bvalid && bready;
                r  = bresp;
                @(posedge clk);
                if (ag) awvalid <= 1'b0;
                if (wg) wvalid <= 1'b0;
            end while (!bg);
            bready <= 1'b0;
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ag, rg;
        begin
            @(posedge clk);
            araddr <= a;
            {arvalid, rready} <= 2'b11;
            do
            begin
                @(negedge clk);
                ag = arvalid && arready;
                rg = rvalid && rready;
                d  = rdata;
                r  = rresp;
                @(posedge clk);
                if (ag) arvalid <= 1'b0;
            end while (!rg);
            rready <= 1'b0;
        end
    endtask : axi_rd

    // Keeps a trial bit while the input is above the (optionally compressed) trial level.
    function automatic logic [15:0] sar_exp(input logic [15:0] v, input logic gc);
        logic [15:0] r, t, d;
        logic [31:0] p;
        begin
            r = 16'h0;
            for (int i = 15; i >= 0; i--)
            begin
                t = r | (16'h1 << i);
                p = {16'h0, t} * 32'h0000cccd;
                d = gc ? 16'h199a + p[31:16] : t;
                if (v > d) r = t;
            end
            return r ^ 16'h8000;
        end
    endfunction : sar_exp

    task automatic t_reset_state;
        logic [31:0] d;
        logic [1:0]  r;
        begin
            chk(busy === 1'b0 && track === 1'b1 && pwr === 1'b0, "idle after reset");
            axi_rd(8'h00, d, r);
            chk(d[0] === 1'b1 && r === 2'h0, "control reset value");
            axi_rd(8'h10, d, r);
            chk(r === 2'h2 && d === 32'h0, "unmapped read");
            axi_wr(8'h14, 32'h1, r);
            chk(r === 2'h2, "unmapped write");
        end
    endtask : t_reset_state

    task automatic t_oe;
        begin
            for (int i = 0; i < 3; i++)
            begin
                @(posedge clk);
                chain <= i[1];
                rd_en <= i[0];
                repeat (6) @(negedge clk);
                chk(sdo_oe === (i[1] | i[0]), "output enable");
            end
        end
    endtask : t_oe

    task automatic t_conv(input logic [15:0] v, input logic gs, input logic ch, input int nb);
        logic [31:0] c0, c1, rd, w;
        logic [1:0]  r;
        logic [15:0] e;
        int          n;
        begin
            e = sar_exp(v, !gs);
            axi_rd(8'h0c, c0, r);
            {strap, chain, rd_en} <= {gs, ch, 1'b1};
            vin <= v;
            repeat (4) @(posedge clk);
            conv_pin <= 1'b1;
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end while (busy !== 1'b1 && n < 10);
            chk(busy === 1'b1 && track === 1'b0 && pwr === 1'b1, "start");
            @(posedge clk);
            conv_pin <= 1'b0;
            n = 0;
            while (busy === 1'b1 && n < 200)
            begin
                n++;
                @(negedge clk);
            end
            chk(n == 48 && pwr === 1'b0 && track === 1'b1, "conversion span");
            axi_rd(8'h08, rd, r);
            chk(rd[15:0] === e, "result register");
            axi_rd(8'h0c, c1, r);
            chk(c1[15:0] === c0[15:0] + 16'h1, "conversion count");
            axi_rd(8'h04, rd, r);
            chk(rd === {28'h0000000, !gs, ch, 2'b10} && r === 2'h0, "status word");
            host_u.read_frame(nb, w);
            chk(w[nb-1 -: 16] === e, "serial word");
            if (nb > 16) chk(w[15:0] === UP_WORD, "upstream data");
        end
    endtask : t_conv

    task automatic t_en;
        logic [1:0] r;
        int         n;
        begin
            axi_wr(8'h00, 32'h0, r);
            conv_pin <= 1'b1;
            repeat (3) @(posedge clk);
            conv_pin <= 1'b0;
            repeat (10) @(negedge clk);
            chk(busy === 1'b0 && r === 2'h0, "start while disabled");
            axi_wr(8'h00, 32'h3, r);
            n = 0;
            while (busy !== 1'b1 && n < 10)
            begin
                n++;
                @(negedge clk);
            end
            chk(busy === 1'b1, "register start");
            @(posedge clk);
            ce <= 1'b0;
            repeat (60) @(negedge clk);
            chk(busy === 1'b1 && awready === 1'b0 && arready === 1'b0, "clock enable freeze");
            @(posedge clk);
            ce <= 1'b1;
            n = 0;
            while (busy === 1'b1 && n < 100)
            begin
                n++;
                @(negedge clk);
            end
            chk(busy === 1'b0, "register conversion end");
        end
    endtask : t_en

    initial
    begin
        {rst, ce, strap, conv_pin, chain, rd_en} = 6'b111000;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b0;
        {awaddr, araddr, wdata, vin} = '0;
        wstrb = 4'hf;
        n_mismatch = 0;
        check_count = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset_state();
        t_oe();
        t_conv(16'h1235, 1'b1, 1'b0, 16);
        t_conv(16'h1235, 1'b0, 1'b0, 16);
        t_conv(16'hf0f1, 1'b1, 1'b1, 32);
        t_conv(16'h0001, 1'b1, 1'b0, 16);
        t_en();
        test_done();
    end

    initial
    begin
        #300000;
        n_mismatch++;
        test_done();
    end
endmodule : sac_top_bench
